// *** src/afh_pkg.sv ***
// Purpose: Shared constants, types and lookup for the sample FIFO host port
// Assumes: One 20 MHz system clock; processor pins already synchronous
// Notes: Control register 1 fields, Wishbone map and pulse timing live here
package afh_pkg;

    // System clock and the two pulse-width sources
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONVERSION_CLOCK_PERIOD_NS = 200;
    localparam int OSC_PERIOD_NS = 100;
    // Half periods round down, never below one cycle
    localparam int PULSE_CONV_CYC = ((CONVERSION_CLOCK_PERIOD_NS / 2) / CLK_PERIOD_NS < 1) ? 1 :
        (CONVERSION_CLOCK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int PULSE_OSC_CYC = ((OSC_PERIOD_NS / 2) / CLK_PERIOD_NS < 1) ? 1 :
        (OSC_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int PCNT_W = 4;

    // Data path and FIFO geometry
    localparam int DATA_W = 10;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;

    // Control register 1 bit positions; reset values of control registers 0 and 1
    localparam int OVF_BIT = 1;
    localparam int LVL_LSB = 2;
    localparam int LVL_MSB = 3;
    localparam int TYPE_BIT = 4;
    localparam int POL_BIT = 5;
    localparam int RW_BIT = 6;
    localparam logic [DATA_W-1:0] CTRL0_RESET = 10'h000;
    localparam logic [DATA_W-1:0] CTRL1_RESET = 10'h030;

    // Processor port register select
    localparam logic PADDR_CTRL0 = 1'b0;
    localparam logic PADDR_CTRL1 = 1'b1;

    // Wishbone byte offsets
    localparam logic [7:0] WB_STATUS = 8'h00;
    localparam logic [7:0] WB_MASK = 8'h04;
    localparam logic [7:0] WB_CTRL0 = 8'h08;
    localparam logic [7:0] WB_CTRL1 = 8'h0C;
    localparam logic [7:0] WB_FILL = 8'h10;

    // Interrupt status bits
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [2:0] {
        TS_ARMED = 3'b001,
        TS_SHOW = 3'b010,
        TS_DRAIN = 3'b100
    } afh_trig_e;

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] fill;
        logic [DATA_W-1:0] ctrl0;
        logic [DATA_W-1:0] ctrl1;
        afh_trig_e trig;
        logic [CNT_W-1:0] reads_left;
        logic [PCNT_W-1:0] pulse_cnt;
        logic [1:0] exp_chan;
        logic rd_q;
        logic wr_q;
        logic [DATA_W-1:0] dout;
        logic dav;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic wb_ack;
        logic [31:0] wb_dat;
    } afh_state_s;

    // Trigger word count from level code and active channels minus one; 0 means none
    function automatic logic [CNT_W-1:0] trig_count(input logic [1:0] code,
                                                    input logic [1:0] chans);
        logic [CNT_W-1:0] t;
        t = 5'h00;
        case ({chans, code})
            4'h0: t = 5'h01;
            4'h1: t = 5'h04;
            4'h2: t = 5'h08;
            4'h3: t = 5'h0E;
            4'h4: t = 5'h02;
            4'h5: t = 5'h04;
            4'h6: t = 5'h08;
            4'h7: t = 5'h0C;
            4'h8: t = 5'h03;
            4'h9: t = 5'h06;
            4'hA: t = 5'h09;
            4'hB: t = 5'h0C;
            4'hC: t = 5'h04;
            4'hD: t = 5'h08;
            4'hE: t = 5'h0C;
            default: t = 5'h00;
        endcase
        return t;
    endfunction : trig_count

endpackage : afh_pkg

// *** src/afh_host_port.sv ***
// Purpose: Parallel processor port of a sampling converter with sample FIFO
// Assumes: Processor pins synchronous to clk_sys_in; samples arrive tagged by channel
// Notes: Strobes act on their rising edge inside this clock; Wishbone adds IRQ and status
// How it works
// (R1) Control-1 bits 2,3 pick trigger level
// (R2) Every active input counts as one channel
// (R3) One/two channels: 1,4,8,14 / 2,4,8,12
// (R4) Three/four: 3,6,9,12 / 4,8,12,reserved
// (R5) FIFO words stored in fixed channel order
// (R6) Sample-ready asserts when fill reaches count
// (R7) Read strobe: selects and read, no write
// (R8) Read strobe pops word, enables drivers
// (R9) Store strobe: selects and store, no read
// (R10) Store strobe latches control register 0/1
// (R11) Processor ties read high in direction mode
// (R12) Control-1 bit 4: level or pulse
// (R13) Control-1 bit 5: low or high active
// (R14) Level drops on first read, rearm after all
// (R15) Pulse lasts half conversion/oscillator period
// (R16) No new pulse before trigger words read
// (R17) Bit 6 makes store a direction input
// (R18) Bit 1 overflow, clears on read; write empties
// (R19) Sixteen-word FIFO, fill compared to count
`timescale 1ns/10ps
module afh_host_port (
    input wire logic clk_sys_in, // System clock, 20 MHz
    input wire logic sys_rst_in, // Asynchronous reset, active high
    input wire logic chip_select_low_n_in, // Chip select, active low
    input wire logic chip_select_high_in, // Chip select, active high
    input wire logic read_strobe_n_in, // Read input, active low
    input wire logic store_strobe_n_in, // Store input or direction
    input wire logic reg_sel_in, // Register select on the port
    input wire logic [afh_pkg::DATA_W-1:0] data_in, // Bus data from processor
    output logic [afh_pkg::DATA_W-1:0] data_out, // Bus data to processor
    output logic data_oe_n_out, // Bus driver enable, low drives
    output logic sample_ready_out, // Sample-ready signal
    input wire logic [1:0] active_channels_in, // Active channels minus one
    input wire logic single_mode_in, // High in single conversion mode
    input wire logic sample_valid_in, // Conversion word strobe
    input wire logic [1:0] sample_chan_in, // Channel of conversion word
    input wire logic [afh_pkg::DATA_W-1:0] sample_word_in, // Conversion word
    input wire logic [7:0] wb_adr_in, // Wishbone address
    input wire logic [31:0] wb_dat_in, // Wishbone write data
    output logic [31:0] wb_dat_out, // Wishbone read data
    input wire logic [3:0] wb_sel_in, // Wishbone byte selects
    input wire logic wb_we_in, // Wishbone write enable
    input wire logic wb_cyc_in, // Wishbone cycle
    input wire logic wb_stb_in, // Wishbone strobe
    output logic wb_ack_out, // Wishbone acknowledge
    output logic irq_out // Interrupt, active high level
);

    afh_pkg::afh_state_s s;
    afh_pkg::afh_state_s n;
    logic dir_mode;
    logic read_req;
    logic write_req;
    logic rd_int;
    logic wr_int;
    logic rd_rise;
    logic wr_rise;
    logic pop;
    logic ctrl1_read;
    logic fifo_clear;
    logic push_ok;
    logic push;
    logic overflow_evt;
    logic [afh_pkg::CNT_W-1:0] trig_lvl;
    logic wb_req;
    logic trig_evt;

    // Read and write requests; the direction mode ignores the read pin
    // (R17) Direction mode select
    assign dir_mode = s.ctrl1[afh_pkg::RW_BIT];
    // (R11) Read pin ignored here
    assign read_req = dir_mode ? store_strobe_n_in : !read_strobe_n_in;
    assign write_req = dir_mode ? !store_strobe_n_in : !store_strobe_n_in;

    // (R7) Read strobe combination
    assign rd_int = !chip_select_low_n_in && chip_select_high_in && read_req &&
        (dir_mode || store_strobe_n_in);
    // (R9) Store strobe combination
    assign wr_int = !chip_select_low_n_in && chip_select_high_in && write_req &&
        (dir_mode || read_strobe_n_in);
    assign rd_rise = rd_int && !s.rd_q;
    assign wr_rise = wr_int && !s.wr_q;
    assign pop = rd_rise && (reg_sel_in == afh_pkg::PADDR_CTRL0) && (s.fill != 5'h00);
    assign ctrl1_read = rd_rise && (reg_sel_in == afh_pkg::PADDR_CTRL1);
    // (R18) Writing one to bit 1 empties
    assign fifo_clear = wr_rise && (reg_sel_in == afh_pkg::PADDR_CTRL1) &&
        data_in[afh_pkg::OVF_BIT];

    // (R5) Accept only the expected next channel
    assign push_ok = sample_valid_in && (sample_chan_in == s.exp_chan) && !fifo_clear;
    // (R19) Sixteen words; a pop makes room
    assign push = push_ok && ((s.fill != 5'h10) || pop);
    assign overflow_evt = push_ok && !push;

    // (R1) Level field with channel count
    // (R2) Channel count from active inputs
    // (R3) One and two channel table
    // (R4) Three and four channel table
    assign trig_lvl = afh_pkg::trig_count({s.ctrl1[afh_pkg::LVL_MSB], s.ctrl1[afh_pkg::LVL_LSB]},
        active_channels_in);

    assign wb_req = wb_cyc_in && wb_stb_in && !s.wb_ack;
    // (R6) Trigger condition
    assign trig_evt = (s.trig == afh_pkg::TS_ARMED) && (trig_lvl != 5'h00) &&
        (s.fill >= trig_lvl) && !fifo_clear;

    // Next-state logic for the whole port
    always_comb
    begin
        n = s;
        n.rd_q = rd_int;
        n.wr_q = wr_int;
        n.wb_ack = wb_req;

        // (R10) Store strobe latches register
        if (wr_rise)
        begin
            if (reg_sel_in == afh_pkg::PADDR_CTRL0)
            begin
                n.ctrl0 = data_in;
            end
            else
            begin
                // Overflow bit is status only; its written value means clear
                n.ctrl1 = data_in;
                n.ctrl1[afh_pkg::OVF_BIT] = s.ctrl1[afh_pkg::OVF_BIT];
            end
        end

        // (R8) Pop one word per strobe
        if (rd_rise)
        begin
            if (reg_sel_in == afh_pkg::PADDR_CTRL1)
            begin
                n.dout = s.ctrl1;
            end
            else if (s.fill != 5'h00)
            begin
                n.dout = s.mem[s.rd_ptr];
            end
            else
            begin
                n.dout = 10'h000;
            end
        end

        // FIFO pointers and fill
        if (push)
        begin
            n.mem[s.wr_ptr] = sample_word_in;
            n.wr_ptr = s.wr_ptr + 4'h1;
        end
        if (pop)
        begin
            n.rd_ptr = s.rd_ptr + 4'h1;
        end
        if (push && !pop)
        begin
            n.fill = s.fill + 5'h01;
        end
        else if (pop && !push)
        begin
            n.fill = s.fill - 5'h01;
        end
        if (push_ok)
        begin
            n.exp_chan = (s.exp_chan == active_channels_in) ? 2'h0 : s.exp_chan + 2'h1;
        end

        // (R18) Overflow flag, set wins over read clear
        if (ctrl1_read)
        begin
            n.ctrl1[afh_pkg::OVF_BIT] = 1'b0;
        end
        if (overflow_evt)
        begin
            n.ctrl1[afh_pkg::OVF_BIT] = 1'b1;
        end

        // Trigger sequencer: reads pending counted against the trigger words
        if (pop && (s.reads_left != 5'h00))
        begin
            n.reads_left = s.reads_left - 5'h01;
        end
        case (s.trig)
            afh_pkg::TS_ARMED:
            begin
                if (trig_evt)
                begin
                    n.trig = afh_pkg::TS_SHOW;
                    n.reads_left = trig_lvl;
                    // (R15) Pulse width source
                    n.pulse_cnt = single_mode_in ? afh_pkg::PCNT_W'(afh_pkg::PULSE_OSC_CYC) :
                        afh_pkg::PCNT_W'(afh_pkg::PULSE_CONV_CYC);
                end
            end
            afh_pkg::TS_SHOW:
            begin
                if (s.ctrl1[afh_pkg::TYPE_BIT])
                begin
                    // (R15) Pulse ends after half period
                    n.pulse_cnt = s.pulse_cnt - 4'h1;
                    if (s.pulse_cnt == 4'h1)
                    begin
                        n.trig = afh_pkg::TS_DRAIN;
                    end
                end
                // (R14) Level drops on first read
                else if (pop)
                begin
                    n.trig = afh_pkg::TS_DRAIN;
                end
            end
            afh_pkg::TS_DRAIN:
            begin
                // (R14) Rearm after all reads
                // (R16) No pulse before words drained
                if (s.reads_left == 5'h00)
                begin
                    n.trig = afh_pkg::TS_ARMED;
                end
            end
            default:
            begin
                n.trig = afh_pkg::TS_ARMED;
            end
        endcase

        // Emptying the FIFO also rearms the trigger, since the pending words are gone
        if (fifo_clear)
        begin
            n.wr_ptr = 4'h0;
            n.rd_ptr = 4'h0;
            n.fill = 5'h00;
            n.exp_chan = 2'h0;
            n.trig = afh_pkg::TS_ARMED;
            n.reads_left = 5'h00;
        end

        // (R12) Level or pulse shape
        // (R13) Polarity applied
        n.dav = (n.trig == afh_pkg::TS_SHOW) ? n.ctrl1[afh_pkg::POL_BIT] :
            !n.ctrl1[afh_pkg::POL_BIT];

        // Sticky interrupt bits; an event in the clearing cycle wins
        if (wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == afh_pkg::WB_STATUS))
        begin
            n.irq_stat = s.irq_stat & ~wb_dat_in[afh_pkg::IRQ_W-1:0];
        end
        if (trig_evt)
        begin
            n.irq_stat[afh_pkg::IRQ_TRIG] = 1'b1;
        end
        if (overflow_evt)
        begin
            n.irq_stat[afh_pkg::IRQ_OVF] = 1'b1;
        end
        if (wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == afh_pkg::WB_MASK))
        begin
            n.irq_mask = wb_dat_in[afh_pkg::IRQ_W-1:0];
        end

        // Wishbone read mux; unmapped offsets answer with zero
        n.wb_dat = 32'h0000_0000;
        if (wb_req && !wb_we_in)
        begin
            case (wb_adr_in)
                afh_pkg::WB_STATUS: n.wb_dat = {30'h0, s.irq_stat};
                afh_pkg::WB_MASK: n.wb_dat = {30'h0, s.irq_mask};
                afh_pkg::WB_CTRL0: n.wb_dat = {22'h0, s.ctrl0};
                afh_pkg::WB_CTRL1: n.wb_dat = {22'h0, s.ctrl1};
                afh_pkg::WB_FILL: n.wb_dat = {24'h0, s.trig, s.fill};
                default: n.wb_dat = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s <= '0;
            s.ctrl0 <= afh_pkg::CTRL0_RESET;
            s.ctrl1 <= afh_pkg::CTRL1_RESET;
            s.trig <= afh_pkg::TS_ARMED;
            s.dav <= 1'b0;
        end
        else
        begin
            s <= n;
        end
    end

    // Outputs; drivers enable one cycle into the read strobe and release at once when it drops
    assign data_out = s.dout;
    assign data_oe_n_out = !(rd_int && s.rd_q);
    assign sample_ready_out = s.dav;
    assign wb_ack_out = s.wb_ack;
    assign wb_dat_out = s.wb_dat;
    assign irq_out = |(s.irq_stat & s.irq_mask);

    // Checks
    // (R6) Trigger condition shows
    a_trig_shows: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R6
        trig_evt |=> (s.trig == afh_pkg::TS_SHOW) && (sample_ready_out == s.ctrl1[5]))
        else $error("sample-ready not raised on trigger");
    // (R14) Level drop on read
    a_level_drop: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R14
        (s.trig == afh_pkg::TS_SHOW) && !s.ctrl1[4] && pop |=> s.trig != afh_pkg::TS_SHOW)
        else $error("level sample-ready not dropped on first read");
    // (R15) Pulse width check
    a_pulse_width: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R15
        trig_evt && s.ctrl1[4] && !single_mode_in && !wr_rise |=>
        (s.trig == afh_pkg::TS_SHOW)[*2] ##1 (s.trig != afh_pkg::TS_SHOW))
        else $error("pulse width wrong");
    // (R16) No early pulse
    a_no_early: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R16
        (s.trig == afh_pkg::TS_DRAIN) && (s.reads_left > 5'h01) |=>
        s.trig != afh_pkg::TS_SHOW)
        else $error("pulse before trigger words read");
    // (R18) Overflow flag set
    a_ovf_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R18
        overflow_evt |=> s.ctrl1[1] && s.irq_stat[1])
        else $error("overflow not flagged");
    // (R18) Overflow cleared by read
    a_ovf_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R18
        ctrl1_read && !overflow_evt |=> !s.ctrl1[1])
        else $error("overflow not cleared by read");
    // (R18) Clear empties FIFO
    a_fifo_empty: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R18
        fifo_clear |=> (s.fill == 5'h00) && (s.trig == afh_pkg::TS_ARMED))
        else $error("fifo not emptied");
    // (R10) Store latches register 0
    a_store_latch: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R10
        wr_rise && (reg_sel_in == 1'b0) |=> s.ctrl0 == $past(data_in))
        else $error("control register 0 not latched");
    // (R8) Pop advances read pointer
    a_pop_word: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R8
        pop && !fifo_clear |=> (s.rd_ptr == $past(s.rd_ptr) + 4'h1) && !data_oe_n_out
        ##0 (s.dout == $past(s.mem[s.rd_ptr])))
        else $error("read did not pop one word");
    // (R7) Strobe excludes write
    a_strobe_excl: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R7
        !(rd_int && wr_int))
        else $error("read and store strobes together");
    // (R15) Single-mode pulse is one cycle
    a_pulse_single: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R15
        trig_evt && s.ctrl1[4] && single_mode_in && !wr_rise |=>
        (s.trig == afh_pkg::TS_SHOW) ##1 (s.trig != afh_pkg::TS_SHOW))
        else $error("single-mode pulse width wrong");
    // (R14) Level holds until a read
    a_level_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R14
        (s.trig == afh_pkg::TS_SHOW) && !s.ctrl1[4] && !pop && !fifo_clear |=>
        s.trig == afh_pkg::TS_SHOW)
        else $error("level sample-ready dropped without a read");

    c_level_cycle: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (s.trig == afh_pkg::TS_SHOW) && !s.ctrl1[4] ##1 (s.trig == afh_pkg::TS_DRAIN)
        ##[1:64] (s.trig == afh_pkg::TS_ARMED));
    c_pulse: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        trig_evt && s.ctrl1[4]);
    c_overflow: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) overflow_evt);
    c_dir_read: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        dir_mode && pop);
    c_dir_write: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        dir_mode && wr_rise);

endmodule : afh_host_port

// *** testbench/afh_proc_model.sv ***
// Purpose: Processor model driving the parallel port of the host port
// Assumes: Pins move just after a rising edge; answers taken at the falling edge
// Notes: Released bus data is inverted so a stale word cannot pass for a fresh one
`timescale 1ns/10ps
module afh_proc_model (
    input wire logic clk_sys_in, // System clock
    output logic csl_n_out, // Chip select, active low
    output logic csh_out, // Chip select, active high
    output logic read_n_out, // Read input, active low
    output logic store_n_out, // Store input or direction
    output logic sel_out, // Register select
    output logic [afh_pkg::DATA_W-1:0] wdata_out, // Data to the port
    input wire logic [afh_pkg::DATA_W-1:0] rdata_in, // Data from the port
    input wire logic oe_n_in // Port driver enable, low drives
);
    logic dir_mode;

    // Idle bus at time zero, selects inactive
    initial
    begin
        dir_mode = 1'b0;
        csl_n_out = 1'b1;
        csh_out = 1'b0;
        read_n_out = 1'b1;
        store_n_out = 1'b1;
        sel_out = 1'b0;
        wdata_out = 10'h155;
    end

    // Strobe held over three edges, so only its first edge is taken
    task automatic access(input logic wr, input logic sel,
        input logic [afh_pkg::DATA_W-1:0] d,
        output logic [afh_pkg::DATA_W-1:0] q, output logic oe_n);
        @(posedge clk_sys_in);
        csl_n_out <= 1'b0;
        csh_out <= 1'b1;
        sel_out <= sel;
        wdata_out <= d;
        store_n_out <= !wr;
        read_n_out <= dir_mode | wr;
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        q = rdata_in;
        oe_n = oe_n_in;
        @(posedge clk_sys_in);
        csl_n_out <= 1'b1;
        csh_out <= 1'b0;
        read_n_out <= 1'b1;
        store_n_out <= 1'b1;
        wdata_out <= ~d;
        if (wr && sel)
            dir_mode = d[afh_pkg::RW_BIT];
        @(posedge clk_sys_in);
    endtask : access
endmodule : afh_proc_model

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the sample FIFO host port
// Assumes: Processor model drives the port; bench drives samples and Wishbone
// Notes: Reference FIFO is a queue; trigger counts come from a table here
`timescale 1ns/10ps
module tb;
    logic clk_sys_in, sys_rst_in, csl_n, csh, rd_n, st_n, rsel, oe_n, rdy, irq;
    logic [afh_pkg::DATA_W-1:0] pw, pr, s_w, ctrl0_m, ctrl1_m, q;
    logic [1:0] chans, s_ch;
    logic single, s_val, wb_we, wb_cyc, wb_stb, wb_ack, pol, ovf_m, o;
    logic [7:0] wb_adr;
    logic [31:0] wb_dw, wb_dr, rd, r;
    logic [3:0] wb_sel;
    logic [9:0] fq[$];
    int n_mismatch, checks_done, cyc_n, act, cnt, nch;
    int tbl[4][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}, '{3, 6, 9, 12}, '{4, 8, 12, 0}};

    afh_host_port afh_host_port_i (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .chip_select_low_n_in(csl_n), .chip_select_high_in(csh),
        .read_strobe_n_in(rd_n), .store_strobe_n_in(st_n), .reg_sel_in(rsel),
        .data_in(pw), .data_out(pr), .data_oe_n_out(oe_n), .sample_ready_out(rdy),
        .active_channels_in(chans), .single_mode_in(single), .sample_valid_in(s_val),
        .sample_chan_in(s_ch), .sample_word_in(s_w), .wb_adr_in(wb_adr),
        .wb_dat_in(wb_dw), .wb_dat_out(wb_dr), .wb_sel_in(wb_sel), .wb_we_in(wb_we),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_ack_out(wb_ack), .irq_out(irq));

    afh_proc_model afh_proc_model_i (
        .clk_sys_in(clk_sys_in), .csl_n_out(csl_n), .csh_out(csh), .read_n_out(rd_n),
        .store_n_out(st_n), .sel_out(rsel), .wdata_out(pw), .rdata_in(pr),
        .oe_n_in(oe_n));

    // Free-running clock; ready activity counted for pulse widths
    always #25 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in)
        if (rdy === pol)
            act++;

    // Hang guard, well above the fewer than two thousand cycles the tests need
    always @(posedge clk_sys_in)
    begin
        cyc_n++;
        if (cyc_n == 30000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic cmp_flag(input logic g, input logic e);
        cmp(32'(g), 32'(e));
    endtask : cmp_flag

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    function automatic logic [9:0] cfg(input logic d, input logic p, input logic t,
        input logic [1:0] c);
        return {3'h0, d, p, t, c, 2'h2};
    endfunction : cfg

    // Classic cycle: held until ack is sampled at a rising edge, released at that edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] qd);
        @(posedge clk_sys_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dw <= d;
        wb_sel <= 4'hF;
        do @(posedge clk_sys_in); while (wb_ack !== 1'b1);
        qd = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wb

    // Port write; the clear bit empties the queue and is never stored
    task automatic port_wr(input logic sel, input logic [9:0] d);
        afh_proc_model_i.access(1'b1, sel, d, q, o);
        if (!sel)
            ctrl0_m = d;
        else
        begin
            ctrl1_m = d & 10'h3FD;
            if (d[1])
            begin
                fq.delete();
                nch = 0;
            end
        end
    endtask : port_wr

    task automatic port_rd(input logic sel);
        logic [9:0] e;
        e = 10'h000;
        if (sel)
            e = ctrl1_m | {ovf_m, 1'b0};
        else if (fq.size() > 0)
            e = fq.pop_front();
        if (sel)
            ovf_m = 1'b0;
        afh_proc_model_i.access(1'b0, sel, ~e, q, o);
        cmp(32'(q), 32'(e));
        cmp_flag(o, 1'b0);
    endtask : port_rd

    // Samples go in channel order; a full queue drops the word and flags it
    task automatic push(input int n);
        repeat (n)
        begin
            r = $urandom;
            @(posedge clk_sys_in);
            s_val <= 1'b1;
            s_ch <= 2'(nch);
            s_w <= r[9:0];
            @(posedge clk_sys_in);
            s_val <= 1'b0;
            s_w <= ~r[9:0];
            if (fq.size() < 16)
                fq.push_back(r[9:0]);
            else
                ovf_m = 1'b1;
            nch = (nch == int'(chans)) ? 0 : nch + 1;
        end
    endtask : push

    initial
    begin
        {clk_sys_in, single, s_val, wb_we, wb_cyc, wb_stb, ovf_m, pol} = 8'h00;
        {chans, s_ch, wb_sel, wb_adr, wb_dw, s_w} = 58'h0;
        {nch, n_mismatch, checks_done, cyc_n, act} = 160'h0;
        sys_rst_in = 1'b1;
        ctrl0_m = 10'h000;
        ctrl1_m = 10'h030;
        void'($urandom(32'hD789A282));
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_sys_in);
        cmp_flag(rdy, 1'b0);
        wb(1'b0, afh_pkg::WB_CTRL1, 32'h0, rd);
        cmp(rd, 32'h030);
        r = $urandom;
        port_wr(1'b0, r[9:0]);
        wb(1'b0, afh_pkg::WB_CTRL0, 32'h0, rd);
        cmp(rd, 32'(ctrl0_m));
        done("reset and store");
        // Every channel count and level code, in level form
        for (int ch = 0; ch < 4; ch++)
            for (int cd = 0; cd < 4; cd++)
            begin
                cnt = tbl[ch][cd];
                pol = cd[0];
                @(posedge clk_sys_in);
                chans <= 2'(ch);
                port_wr(1'b1, cfg(1'b0, pol, 1'b0, 2'(cd)));
                repeat ((cnt == 0) ? 16 : cnt)
                begin
                    push(1);
                    repeat (2) @(negedge clk_sys_in);
                    cmp_flag(rdy, (cnt > 0 && fq.size() >= cnt) ? pol : !pol);
                end
                while (fq.size() > 0)
                begin
                    port_rd(1'b0);
                    @(negedge clk_sys_in);
                    cmp_flag(rdy, !pol);
                end
            end
        done("trigger table");
        // Pulse width by mode, and no second pulse before the words are read
        @(posedge clk_sys_in);
        chans <= 2'h0;
        for (int m = 0; m < 4; m++)
        begin
            pol = m[0];
            @(posedge clk_sys_in);
            single <= m[1];
            port_wr(1'b1, cfg(1'b0, pol, 1'b1, 2'h1));
            act = 0;
            push(4);
            repeat (8) @(negedge clk_sys_in);
            cmp(act, m[1] ? afh_pkg::PULSE_OSC_CYC : afh_pkg::PULSE_CONV_CYC);
            act = 0;
            push(4);
            repeat (8) @(negedge clk_sys_in);
            cmp(act, 0);
        end
        done("pulse");
        // Overflow, events, mask and clear
        wb(1'b1, afh_pkg::WB_MASK, 32'h0, rd);
        wb(1'b1, afh_pkg::WB_STATUS, 32'h3, rd);
        pol = 1'b1;
        port_wr(1'b1, cfg(1'b0, 1'b1, 1'b0, 2'h3));
        push(17);
        wb(1'b0, afh_pkg::WB_FILL, 32'h0, rd);
        cmp(32'(rd[4:0]), 32'h10);
        wb(1'b0, afh_pkg::WB_STATUS, 32'h0, rd);
        cmp(rd, 32'h3);
        cmp_flag(irq, 1'b0);
        wb(1'b1, afh_pkg::WB_MASK, 32'h2, rd);
        @(negedge clk_sys_in);
        cmp_flag(irq, 1'b1);
        wb(1'b1, afh_pkg::WB_STATUS, 32'h2, rd);
        @(negedge clk_sys_in);
        cmp_flag(irq, 1'b0);
        port_rd(1'b1);
        port_rd(1'b1);
        while (fq.size() > 0)
            port_rd(1'b0);
        wb(1'b1, 8'h14, 32'h3FF, rd);
        wb(1'b0, 8'h14, 32'h0, rd);
        cmp(rd, 32'h0);
        wb(1'b1, afh_pkg::WB_CTRL1, 32'h0, rd);
        wb(1'b0, afh_pkg::WB_CTRL1, 32'h0, rd);
        cmp(rd, 32'(ctrl1_m));
        done("overflow and irq");
        // Combined direction input
        port_wr(1'b1, cfg(1'b1, 1'b1, 1'b0, 2'h0));
        push(1);
        port_rd(1'b0);
        port_wr(1'b1, cfg(1'b0, 1'b1, 1'b0, 2'h0));
        port_rd(1'b1);
        done("direction");
        end_sim();
    end
endmodule : tb
